// [pkg/dbs_pkg.sv]
package dbs_pkg;

  // command codes decoded from the command/address bus
  typedef enum logic [3:0] {
    DBS_CMD_NOP    = 4'h0,
    DBS_CMD_ACT    = 4'h1,
    DBS_CMD_RD     = 4'h2,
    DBS_CMD_WR     = 4'h3,
    DBS_CMD_PRE    = 4'h4,
    DBS_CMD_PREA   = 4'h5,
    DBS_CMD_REFPB  = 4'h6,
    DBS_CMD_REFAB  = 4'h7,
    DBS_CMD_MRW    = 4'h8,
    DBS_CMD_MRR    = 4'h9,
    DBS_CMD_RESET  = 4'ha,
    DBS_CMD_MRWRST = 4'hb
  } dbs_cmd_e;

  // per-bank state
  typedef enum logic [3:0] {
    DBS_ST_IDLE    = 4'h0,
    DBS_ST_ACTVG   = 4'h1,
    DBS_ST_ACTIVE  = 4'h2,
    DBS_ST_READ    = 4'h3,
    DBS_ST_WRITE   = 4'h4,
    DBS_ST_PRECH   = 4'h5,
    DBS_ST_RDAP    = 4'h6,
    DBS_ST_WRAP    = 4'h7,
    DBS_ST_REFPB   = 4'h8,
    DBS_ST_AMRR    = 4'h9
  } dbs_bank_e;

  // device-wide state
  typedef enum logic [3:0] {
    DBS_DV_PWRON   = 4'h0,
    DBS_DV_RUN     = 4'h1,
    DBS_DV_RESETNG = 4'h2,
    DBS_DV_REFAB   = 4'h3,
    DBS_DV_MRW     = 4'h4,
    DBS_DV_IMRR    = 4'h5,
    DBS_DV_RMRR    = 4'h6,
    DBS_DV_PREA    = 4'h7
  } dbs_dev_e;

  typedef struct packed {
    logic       valid;
    dbs_cmd_e   cmd;
    logic [2:0] bank;
    logic       auto_close_flag;
  } dbs_req_s;

  localparam int DBS_NBANK = 8;
  localparam int DBS_CLK_MHZ = 50;
  // times in ns
  localparam int DBS_ROW_PRECHARGE_TIME_NS = 18;
  localparam int DBS_ROW_TO_COLUMN_DELAY_NS = 18;
  localparam int DBS_PER_BANK_REFRESH_CYCLE_NS = 90;
  localparam int DBS_ALL_BANK_REFRESH_CYCLE_NS = 210;
  localparam int DBS_MODE_REG_READ_TIME_NS = 80;
  localparam int DBS_MODE_REG_WRITE_TIME_NS = 200;
  localparam int DBS_BURST_CYC = 4;
  localparam int DBS_INIT_CYC = 64;
  localparam int DBS_EXIT_CYC = 2;
  // least times round up to whole cycles
  localparam int DBS_RP_CYC = (DBS_ROW_PRECHARGE_TIME_NS * DBS_CLK_MHZ + 999) / 1000;
  localparam int DBS_RCD_CYC = (DBS_ROW_TO_COLUMN_DELAY_NS * DBS_CLK_MHZ + 999) / 1000;
  localparam int DBS_RFCPB_CYC = (DBS_PER_BANK_REFRESH_CYCLE_NS * DBS_CLK_MHZ + 999) / 1000;
  localparam int DBS_RFCAB_CYC = (DBS_ALL_BANK_REFRESH_CYCLE_NS * DBS_CLK_MHZ + 999) / 1000;
  localparam int DBS_MRR_CYC = (DBS_MODE_REG_READ_TIME_NS * DBS_CLK_MHZ + 999) / 1000;
  localparam int DBS_MRW_CYC = (DBS_MODE_REG_WRITE_TIME_NS * DBS_CLK_MHZ + 999) / 1000;
  localparam int DBS_CNT_W = 8;

endpackage : dbs_pkg

// [design/dbs_bank_fsm.sv]
module dbs_bank_fsm
  import dbs_pkg::*;
#(
  parameter int NBANK = DBS_NBANK
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // command bus pins
  input wire logic i_cke,
  input wire dbs_pkg::dbs_req_s i_req,
  // state view
  output dbs_pkg::dbs_dev_e o_dev_state,
  output logic [NBANK*4-1:0] o_bank_state,
  output logic o_all_idle,
  output logic o_cmd_taken
);
  import dbs_pkg::*;

  // local copies of the timing counts so that property delays read as plain constants
  localparam int RCD_CYC = DBS_RCD_CYC;
  localparam int RP_CYC = DBS_RP_CYC;
  localparam int RFCPB_CYC = DBS_RFCPB_CYC;
  localparam int MRW_CYC = DBS_MRW_CYC;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: the first stage feeds the second stage only
  logic cke_m_q, cke_s_q, cke_p_q;
  dbs_req_s req_m_q, req_s_q;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cke_m_q <= 1'b0;
      cke_s_q <= 1'b0;
      cke_p_q <= 1'b0;
      req_m_q <= '0;
      req_s_q <= '0;
    end else begin
      cke_m_q <= i_cke;
      cke_s_q <= cke_m_q;
      cke_p_q <= cke_s_q;
      req_m_q <= i_req;
      req_s_q <= req_m_q;
    end
  end

  // exit time counter after clock enable returns high
  logic [DBS_CNT_W-1:0] exit_q;
  logic run_ok;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      exit_q <= '0;
    end else if (!cke_s_q) begin
      exit_q <= DBS_CNT_W'(DBS_EXIT_CYC);
    end else if (exit_q != '0) begin
      exit_q <= exit_q - 1'b1;
    end
  end
  assign run_ok = cke_s_q && cke_p_q && (exit_q == '0);

  ////////////////////////////////////////////////////////////////////////////
  // command qualification
  logic cmd_v;
  dbs_cmd_e cmd;
  logic [2:0] ba;
  logic ap;
  assign cmd_v = req_s_q.valid && run_ok && (req_s_q.cmd != DBS_CMD_NOP);
  assign cmd = req_s_q.cmd;
  assign ba = req_s_q.bank;
  assign ap = req_s_q.auto_close_flag;

  dbs_bank_e bank_q [NBANK];
  logic [DBS_CNT_W-1:0] bcnt_q [NBANK];
  logic [NBANK-1:0] bidle;
  dbs_dev_e dev_q;
  logic [DBS_CNT_W-1:0] dcnt_q;

  // device-wide ops in run other than precharge-all need all banks idle; reset write at power-on and mode read while resetting skip this
  assign o_all_idle = (&bidle) && (dev_q == DBS_DV_RUN);
  assign o_cmd_taken = cmd_v;
  assign o_dev_state = dev_q;

  ////////////////////////////////////////////////////////////////////////////
  // device-wide state machine
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      dev_q <= DBS_DV_PWRON;
      dcnt_q <= '0;
    end else begin
      if (dcnt_q != '0) begin
        dcnt_q <= dcnt_q - 1'b1;
      end
      case (dev_q)
        DBS_DV_PWRON: begin
          if (cmd_v && cmd == DBS_CMD_MRWRST) begin
            dev_q <= DBS_DV_RESETNG;
            dcnt_q <= DBS_CNT_W'(DBS_INIT_CYC);
          end
        end
        DBS_DV_RUN: begin
          if (cmd_v && o_all_idle) begin
            case (cmd)
              DBS_CMD_REFAB: begin
                dev_q <= DBS_DV_REFAB;
                dcnt_q <= DBS_CNT_W'(DBS_RFCAB_CYC - 1);
              end
              DBS_CMD_MRW: begin
                dev_q <= DBS_DV_MRW;
                dcnt_q <= DBS_CNT_W'(DBS_MRW_CYC - 1);
              end
              DBS_CMD_MRR: begin
                dev_q <= DBS_DV_IMRR;
                dcnt_q <= DBS_CNT_W'(DBS_MRR_CYC - 1);
              end
              DBS_CMD_RESET: begin
                dev_q <= DBS_DV_RESETNG;
                dcnt_q <= DBS_CNT_W'(DBS_INIT_CYC);
              end
              default: ;
            endcase
          end
          if (cmd_v && cmd == DBS_CMD_PREA) begin
            dev_q <= DBS_DV_PREA;
            dcnt_q <= DBS_CNT_W'(DBS_RP_CYC - 1);
          end
        end
        DBS_DV_RESETNG: begin
          if (cmd_v && cmd == DBS_CMD_MRR) begin
            dev_q <= DBS_DV_RMRR;
            dcnt_q <= DBS_CNT_W'(DBS_MRR_CYC - 1);
          end else if (dcnt_q == '0) begin
            dev_q <= DBS_DV_RUN;
          end
        end
        // transient states ignore every command until their time ends
        DBS_DV_REFAB, DBS_DV_MRW, DBS_DV_IMRR, DBS_DV_RMRR, DBS_DV_PREA: begin
          if (dcnt_q == '0) begin
            dev_q <= DBS_DV_RUN;
          end
        end
        default: dev_q <= DBS_DV_PWRON;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-bank state machines
  for (genvar b = 0; b < NBANK; b++) begin : g_bank
    logic hit;
    assign hit = cmd_v && (ba == 3'(b)) && (dev_q == DBS_DV_RUN);
    assign bidle[b] = (bank_q[b] == DBS_ST_IDLE);
    assign o_bank_state[b*4 +: 4] = bank_q[b];

    always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
        bank_q[b] <= DBS_ST_IDLE;
        bcnt_q[b] <= '0;
      end else begin
        if (bcnt_q[b] != '0) begin
          bcnt_q[b] <= bcnt_q[b] - 1'b1;
        end
        if (cmd_v && cmd == DBS_CMD_PREA && dev_q == DBS_DV_RUN) begin
          bank_q[b] <= DBS_ST_IDLE;
          bcnt_q[b] <= '0;
        end else begin
          case (bank_q[b])
            DBS_ST_IDLE: begin
              if (hit && cmd == DBS_CMD_ACT) begin
                bank_q[b] <= DBS_ST_ACTVG;
                bcnt_q[b] <= DBS_CNT_W'(DBS_RCD_CYC - 1);
              end else if (hit && cmd == DBS_CMD_REFPB) begin
                bank_q[b] <= DBS_ST_REFPB;
                bcnt_q[b] <= DBS_CNT_W'(DBS_RFCPB_CYC - 1);
              end else if (hit && cmd == DBS_CMD_PRE) begin
                bank_q[b] <= DBS_ST_PRECH;
                bcnt_q[b] <= DBS_CNT_W'(DBS_RP_CYC - 1);
              end
            end
            DBS_ST_ACTIVE, DBS_ST_READ, DBS_ST_WRITE: begin
              if (hit && (cmd == DBS_CMD_RD || cmd == DBS_CMD_WR)) begin
                if (ap) begin
                  bank_q[b] <= (cmd == DBS_CMD_RD) ? DBS_ST_RDAP : DBS_ST_WRAP;
                  bcnt_q[b] <= DBS_CNT_W'(DBS_BURST_CYC + DBS_RP_CYC - 1);
                end else begin
                  bank_q[b] <= (cmd == DBS_CMD_RD) ? DBS_ST_READ : DBS_ST_WRITE;
                  bcnt_q[b] <= DBS_CNT_W'(DBS_BURST_CYC - 1);
                end
              end else if (hit && cmd == DBS_CMD_PRE) begin
                bank_q[b] <= DBS_ST_PRECH;
                bcnt_q[b] <= DBS_CNT_W'(DBS_RP_CYC - 1);
              end else if (hit && cmd == DBS_CMD_MRR && bank_q[b] == DBS_ST_ACTIVE) begin
                bank_q[b] <= DBS_ST_AMRR;
                bcnt_q[b] <= DBS_CNT_W'(DBS_MRR_CYC - 1);
              end else if (bank_q[b] != DBS_ST_ACTIVE && bcnt_q[b] == '0) begin
                bank_q[b] <= DBS_ST_ACTIVE; // burst done
              end
            end
            // bank-local transients: commands to this bank are ignored, but a precharge-all still forces them idle
            DBS_ST_ACTVG, DBS_ST_AMRR: begin
              if (bcnt_q[b] == '0) begin
                bank_q[b] <= DBS_ST_ACTIVE;
              end
            end
            DBS_ST_PRECH, DBS_ST_RDAP, DBS_ST_WRAP, DBS_ST_REFPB: begin
              if (bcnt_q[b] == '0) begin
                bank_q[b] <= DBS_ST_IDLE;
              end
            end
            default: bank_q[b] <= DBS_ST_IDLE;
          endcase
        end
      end
    end

    act_rcd_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (bank_q[b] == DBS_ST_IDLE && hit && cmd == DBS_CMD_ACT) |=>
      (bank_q[b] == DBS_ST_ACTVG) ##[RCD_CYC:RCD_CYC] bank_q[b] == DBS_ST_ACTIVE)
      else $error("activate timing wrong");
    pre_rp_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (bank_q[b] != DBS_ST_PRECH) ##1 (bank_q[b] == DBS_ST_PRECH) |->
      ##[RP_CYC:RP_CYC] bank_q[b] == DBS_ST_IDLE)
      else $error("precharge timing wrong");
    refpb_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(bank_q[b] == DBS_ST_REFPB) |-> ##[1:RFCPB_CYC] bank_q[b] == DBS_ST_IDLE)
      else $error("refresh did not end");
    rdwr_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (bank_q[b] == DBS_ST_ACTIVE && hit && cmd == DBS_CMD_RD && !ap) |=>
      bank_q[b] == DBS_ST_READ)
      else $error("read not started");
    ap_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (bank_q[b] inside {DBS_ST_ACTIVE, DBS_ST_READ, DBS_ST_WRITE} && hit &&
      cmd == DBS_CMD_WR && ap) |=>
      bank_q[b] == DBS_ST_WRAP)
      else $error("auto close write lost");
    nop_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (!cmd_v && bank_q[b] == DBS_ST_ACTIVE && dev_q == DBS_DV_RUN) |=>
      bank_q[b] == DBS_ST_ACTIVE)
      else $error("nop changed bank");
  end

  ////////////////////////////////////////////////////////////////////////////
  // device-level checks and coverage
  cke_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (!cke_s_q || !cke_p_q) |-> !o_cmd_taken)
    else $error("command taken with clock enable low");
  mrw_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (dev_q == DBS_DV_RUN && o_all_idle && cmd_v && cmd == DBS_CMD_MRW) |=>
    dev_q == DBS_DV_MRW ##[1:MRW_CYC] dev_q == DBS_DV_RUN)
    else $error("mode write timing wrong");
  refab_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (dev_q == DBS_DV_REFAB) |=> (dev_q == DBS_DV_REFAB || dev_q == DBS_DV_RUN))
    else $error("all-bank refresh interrupted");
  rst_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (dev_q == DBS_DV_PWRON && cmd_v && cmd == DBS_CMD_MRWRST) |=> dev_q == DBS_DV_RESETNG)
    else $error("reset write ignored");

  act_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    bank_q[0] == DBS_ST_ACTVG ##[1:8] bank_q[0] == DBS_ST_ACTIVE);
  rdap_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    bank_q[0] == DBS_ST_RDAP ##[1:16] bank_q[0] == DBS_ST_IDLE);
  refab_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    dev_q == DBS_DV_REFAB ##[1:16] dev_q == DBS_DV_RUN);

endmodule : dbs_bank_fsm

// [bench/dbs_ctl_model.sv]
module dbs_ctl_model
  import dbs_pkg::*;
(
  // clock
  input wire logic i_sys_clk,
  // pins toward the device
  output logic o_cke,
  output dbs_pkg::dbs_req_s o_req,
  // device answer
  input wire logic i_cmd_taken
);
  timeunit 1ns;
  timeprecision 100ps;

  logic taken;

  // clock enable high from the start, command lines quiet
  initial begin
    o_cke = 1'b1;
    o_req = '0;
    taken = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // one command for one cycle; t_refused also passes pairs the state does not list
  task automatic issue(input dbs_cmd_e cmd, input logic [2:0] bank, input logic ap);
    @(posedge i_sys_clk);
    #1;
    o_req = '{valid: 1'b1, cmd: cmd, bank: bank, auto_close_flag: ap};
    @(posedge i_sys_clk);
    #1;
    // released lines flip so a stale bank or flag cannot pass for a held one
    o_req = '{valid: 1'b0, cmd: DBS_CMD_NOP, bank: ~bank, auto_close_flag: ~ap};
    // the flag stands for one cycle, one edge after the pins were sampled
    @(posedge i_sys_clk);
    #1;
    taken = i_cmd_taken;
  endtask : issue

  // clock enable moves just after an edge, like every other pin
  task automatic set_cke(input logic level);
    @(posedge i_sys_clk);
    #1;
    o_cke = level;
  endtask : set_cke
endmodule : dbs_ctl_model

// [bench/testbench.sv]
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import dbs_pkg::*;

  logic i_sys_clk;
  logic i_rst_n;
  logic cke;
  dbs_req_s req;
  dbs_dev_e dev;
  logic [31:0] banks;
  logic all_idle;
  logic taken;
  int errors = 0;
  int checks_done = 0;

  dbs_bank_fsm #(.NBANK(8)) dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_cke(cke),
    .i_req(req), .o_dev_state(dev), .o_bank_state(banks), .o_all_idle(all_idle),
    .o_cmd_taken(taken));

  dbs_ctl_model ctl (.i_sys_clk(i_sys_clk), .o_cke(cke), .o_req(req), .i_cmd_taken(taken));

  // 50 mhz clock
  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) begin
      @(posedge i_sys_clk);
      #1;
    end
  endtask : step

  function automatic logic [3:0] obs(input int b);
    logic [3:0] dv;
    dv = dev;
    return (b < 0) ? dv : banks[b*4 +: 4];
  endfunction : obs

  // counts how long a state stands; b below zero watches the device state
  task automatic dwell(input string what, input int b, input logic [3:0] st, input int n);
    int cnt;
    int w;
    cnt = 0;
    for (w = 0; w < 20 && obs(b) !== st; w++) step(1);
    while (obs(b) === st && cnt < 200) begin
      cnt++;
      step(1);
    end
    chk(what, n, cnt);
  endtask : dwell

  task automatic run(input string what, input dbs_cmd_e c, input int b, input logic ap,
    input int ob, input logic [3:0] st, input int n);
    ctl.issue(c, 3'(b), ap);
    chk({what, " taken"}, 32'h1, 32'(ctl.taken));
    dwell(what, ob, st, n);
  endtask : run

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_init();
    chk("reset dev", DBS_DV_PWRON, dev);
    chk("reset banks", 32'h0, banks);
    chk("reset taken", 32'h0, 32'(taken));
    run("init", DBS_CMD_MRWRST, 0, 1'b0, -1, DBS_DV_RESETNG, DBS_INIT_CYC + 1);
    chk("after init", DBS_DV_RUN, dev);
    chk("all idle", 32'h1, 32'(all_idle));
  endtask : t_init

  task automatic t_rows();
    run("act", DBS_CMD_ACT, 2, 1'b0, 2, DBS_ST_ACTVG, DBS_RCD_CYC);
    chk("active", DBS_ST_ACTIVE, obs(2));
    chk("others", 32'h0, banks & ~32'h0000_0f00);
    run("read", DBS_CMD_RD, 2, 1'b0, 2, DBS_ST_READ, DBS_BURST_CYC);
    run("write", DBS_CMD_WR, 2, 1'b0, 2, DBS_ST_WRITE, DBS_BURST_CYC);
    run("act mrr", DBS_CMD_MRR, 2, 1'b0, 2, DBS_ST_AMRR, DBS_MRR_CYC);
    chk("mrr back", DBS_ST_ACTIVE, obs(2));
    run("pre", DBS_CMD_PRE, 2, 1'b0, 2, DBS_ST_PRECH, DBS_RP_CYC);
    chk("pre idle", DBS_ST_IDLE, obs(2));
    run("pre on idle", DBS_CMD_PRE, 3, 1'b0, 3, DBS_ST_PRECH, DBS_RP_CYC);
  endtask : t_rows

  // follow-on access of the same kind, then the auto-close variant
  task automatic t_auto_close();
    int i;
    for (i = 0; i < 2; i++) begin
      ctl.issue(DBS_CMD_ACT, 3'h4, 1'b0);
      step(3);
      ctl.issue(i ? DBS_CMD_RD : DBS_CMD_WR, 3'h4, 1'b0);
      run("auto close", i ? DBS_CMD_RD : DBS_CMD_WR, 4, 1'b1, 4,
        i ? DBS_ST_RDAP : DBS_ST_WRAP, DBS_BURST_CYC + DBS_RP_CYC);
      chk("ap idle", DBS_ST_IDLE, obs(4));
    end
  endtask : t_auto_close

  task automatic t_device();
    run("ref bank", DBS_CMD_REFPB, 5, 1'b0, 5, DBS_ST_REFPB, DBS_RFCPB_CYC);
    run("ref all", DBS_CMD_REFAB, 0, 1'b0, -1, DBS_DV_REFAB, DBS_RFCAB_CYC);
    run("mrw", DBS_CMD_MRW, 0, 1'b0, -1, DBS_DV_MRW, DBS_MRW_CYC);
    run("idle mrr", DBS_CMD_MRR, 0, 1'b0, -1, DBS_DV_IMRR, DBS_MRR_CYC);
    chk("dev idle", 32'h1, 32'(all_idle));
    ctl.issue(DBS_CMD_ACT, 3'h1, 1'b0);
    step(3);
    run("pre all", DBS_CMD_PREA, 0, 1'b0, -1, DBS_DV_PREA, DBS_RP_CYC);
    chk("pre all banks", 32'h0, banks);
    chk("pre all idle", 32'h1, 32'(all_idle));
  endtask : t_device

  // commands the state does not list leave everything as it was
  task automatic t_refused();
    ctl.issue(DBS_CMD_ACT, 3'h6, 1'b0);
    ctl.issue(DBS_CMD_REFPB, 3'h6, 1'b0);
    chk("refused taken", 32'h1, 32'(ctl.taken));
    step(8);
    chk("no bank ref", DBS_ST_ACTIVE, obs(6));
    ctl.issue(DBS_CMD_REFAB, 3'h0, 1'b0);
    step(8);
    chk("no all ref", DBS_DV_RUN, dev);
    ctl.set_cke(1'b0);
    step(4);
    ctl.issue(DBS_CMD_PRE, 3'h6, 1'b0);
    chk("cke low taken", 32'h0, 32'(ctl.taken));
    step(8);
    chk("cke low hold", DBS_ST_ACTIVE, obs(6));
    ctl.set_cke(1'b1);
    step(8);
    run("pre after cke", DBS_CMD_PRE, 6, 1'b0, 6, DBS_ST_PRECH, DBS_RP_CYC);
  endtask : t_refused

  // reset from run, then a mode read taken while the device initialises
  task automatic t_reset();
    ctl.issue(DBS_CMD_RESET, 3'h0, 1'b0);
    chk("reset cmd taken", 32'h1, 32'(ctl.taken));
    step(1);
    chk("resetting", DBS_DV_RESETNG, dev);
    run("reset mrr", DBS_CMD_MRR, 0, 1'b0, -1, DBS_DV_RMRR, DBS_MRR_CYC);
    chk("reset mrr back", DBS_DV_RUN, dev);
    chk("reset mrr idle", 32'h1, 32'(all_idle));
  endtask : t_reset

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    i_rst_n = 1'b0;
    repeat (2) @(posedge i_sys_clk);
    #1;
    i_rst_n = 1'b1;
    step(8);
    t_init();
    t_rows();
    t_auto_close();
    t_device();
    t_refused();
    t_reset();
    end_of_test();
  end

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge i_sys_clk);
    errors++;
    $display("watchdog expired");
    end_of_test();
  end
endmodule : testbench
